// ==== hira_pkg.sv ====
// Purpose: Shared constants and types of the host indirect register port
// Assumes: 16-bit host bus, eight direct locations, four channels
// Notes: Global indirect locations live below 0100h
package hira_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Direct locations selected by the three host address pins
   localparam logic [2:0] DA_DATA_LO = 3'h0;
   localparam logic [2:0] DA_DATA_HI = 3'h1;
   localparam logic [2:0] DA_WR_ADDR = 3'h2;
   localparam logic [2:0] DA_RD_ADDR = 3'h3;
   localparam logic [2:0] DA_SEQ_BASE = 3'h4;

   ////////////////////////////////////////////////////////////////////////
   // Global indirect locations
   localparam logic [15:0] GA_OUT_CTRL = 16'h0000;
   localparam logic [15:0] GA_RANGE_MAP = 16'h0001;
   localparam logic [15:0] GA_TEST = 16'h0002;
   localparam logic [15:0] GA_TEST_STB = 16'h0003;
   localparam logic [15:0] GA_SYNC_STB = 16'h0004;
   localparam logic [15:0] GA_SYNC_FB = 16'h0005;
   localparam logic [15:0] GA_SOFT_RST = 16'h0006;
   localparam logic [15:0] GA_LAST = 16'h00ff;

   ////////////////////////////////////////////////////////////////////////
   // Field positions and reset values
   localparam int CH_SEL_LSB = 12;
   localparam int IO_SEL_LSB = 8;
   localparam int STAT_REV_LSB = 8;
   localparam logic [7:0] SAT_LOC = 8'h1f;
   localparam logic [31:0] GLB_RESET = 32'h0000_0000;
   localparam logic [15:0] IADDR_RESET = 16'h0000;
   localparam logic [31:0] HOLD_RESET = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////
   // Host pins, internal write bus and global action strobes
   typedef struct packed {
      logic cs_n;
      logic wr_n;
      logic rd_n;
      logic [2:0] addr;
      logic [15:0] data;
   } hira_pins_t;

   typedef struct packed {
      logic strobe;
      logic [15:0] addr;
      logic [31:0] data;
   } hira_wr_t;

   typedef struct packed {
      logic test_data;
      logic sync_out;
      logic sync_out_fb;
      logic soft_reset;
   } hira_act_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_FIRE = 2'b10
   } hira_state_t;

endpackage : hira_pkg

// ==== hira_strobe_sync.sv ====
// Purpose: Bring a host strobe level into ref_clk and mark its start
// Assumes: Strobe held active for at least three clock cycles
// Notes: One pulse per active period, never more
`timescale 1ns/100ps
module hira_strobe_sync (
   input wire logic ref_clk, // System clock
   input wire logic reset, // Synchronous reset, active high
   input wire logic clk_en, // Freezes all state while low
   input wire logic level_in, // Strobe level, active high
   output logic start_pulse // One cycle at strobe start
);
   import hira_pkg::*;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } hira_sync_t;

   hira_sync_t r_reg, r_next;

   // First stage feeds only the second
   always_comb begin
      r_next.s1 = level_in;
      r_next.s2 = r_reg.s1;
      r_next.s3 = r_reg.s2;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         r_reg <= '0;
      end else if (clk_en) begin
         r_reg <= r_next;
      end
   end

   // Rising edge of the settled level
   assign start_pulse = r_reg.s2 & ~r_reg.s3 & clk_en;

endmodule : hira_strobe_sync

// ==== hira_sat_flags.sv ====
// Purpose: Sticky per-channel saturation flags for the status word
// Assumes: Set and clear are one-cycle pulses in ref_clk
// Notes: A set in the clearing cycle survives
`timescale 1ns/100ps
module hira_sat_flags #(
   parameter int NUM_CH = 4
) (
   input wire logic ref_clk, // System clock
   input wire logic reset, // Synchronous reset, active high
   input wire logic clk_en, // Freezes all state while low
   input wire logic [NUM_CH-1:0] sat_set, // Saturation seen, per channel
   input wire logic [NUM_CH-1:0] sat_clr, // Host clear, per channel
   output logic [NUM_CH-1:0] sat_flag // Latched flags
);
   import hira_pkg::*;

   typedef struct packed {
      logic [NUM_CH-1:0] flag;
   } hira_flag_t;

   hira_flag_t r_reg, r_next;
   logic [NUM_CH-1:0] flag_next;

   // Set beats clear so no event is lost
   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      assign flag_next[i] = sat_set[i] | (r_reg.flag[i] & ~sat_clr[i]);
   end

   always_comb begin
      r_next.flag = flag_next;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         r_reg <= '0;
      end else if (clk_en) begin
         r_reg <= r_next;
      end
   end

   assign sat_flag = r_reg.flag;

   a_sat_sticky: assert property (@(posedge ref_clk) disable iff (reset)
      clk_en && r_reg.flag[0] && !sat_clr[0] |=> r_reg.flag[0])
      else $error("saturation flag dropped without clear");

endmodule : hira_sat_flags

// ==== hira_host_port.sv ====
// Purpose: Host parallel port with indirect access to internal registers
// Assumes: Host pins synchronous to ref_clk; strobes held >= 3 cycles
// Notes: Global locations live here; channel and I/O sections outside
`timescale 1ns/100ps
module hira_host_port #(
   parameter int NUM_CH = 4,
   parameter logic [7:0] REV_CODE = 8'h5a // Arbitrary value
) (
   input wire logic ref_clk, // System clock, 100 MHz
   input wire logic reset, // Synchronous reset, active high
   input wire logic clk_en, // Freezes all state while low
   input wire hira_pkg::hira_pins_t host, // Host bus pins
   output logic [15:0] data_out, // Host data bus, driven value
   output logic data_oe, // Host data bus enable
   output hira_pkg::hira_wr_t wr_bus, // Internal indirect write
   output logic [15:0] rd_addr, // Indirect address to sections
   input wire logic [31:0] rd_data_in, // Selected section register
   input wire logic [NUM_CH*16-1:0] seq_data, // Sequenced read words
   output logic [NUM_CH-1:0] seq_advance, // Sequenced pointer step
   input wire logic [NUM_CH-1:0] sat_event, // Channel saturation
   output hira_pkg::hira_act_t actions, // Global action strobes
   output logic [31:0] glb_out_ctrl, // Global location 0
   output logic [31:0] glb_range_map, // Global location 1
   output logic [31:0] glb_test // Global location 2
);
   import hira_pkg::*;

   if (NUM_CH != 4) begin : g_check
      $error("address layout serves exactly four channels");
   end

   ////////////////////////////////////////////////////////////////////////
   // State of the port, one record

   typedef struct packed {
      hira_state_t st;
      logic [31:0] hold;
      logic [15:0] iaddr;
      logic [31:0] wdata;
      logic [31:0] g0;
      logic [31:0] g1;
      logic [31:0] g2;
      logic [15:0] dout;
      logic [NUM_CH-1:0] seq_adv;
      hira_act_t act;
   } hira_port_t;

   hira_port_t r_reg, r_next;

   logic wr_level;
   logic rd_level;
   logic wr_det;
   logic rd_det;
   logic is_global;
   logic fire;
   logic [31:0] rd_src;
   logic [15:0] status;
   logic [NUM_CH-1:0] sat_flag;
   logic [NUM_CH-1:0] sat_clr;
   logic [15:0] rd_word;

   ////////////////////////////////////////////////////////////////////////
   // Strobe synchronisers

   // Chip select qualifies both strobes
   assign wr_level = ~host.cs_n & ~host.wr_n;
   assign rd_level = ~host.cs_n & ~host.rd_n;

   hira_strobe_sync u_wr_sync (
      .ref_clk(ref_clk),
      .reset(reset),
      .clk_en(clk_en),
      .level_in(wr_level),
      .start_pulse(wr_det)
   );

   hira_strobe_sync u_rd_sync (
      .ref_clk(ref_clk),
      .reset(reset),
      .clk_en(clk_en),
      .level_in(rd_level),
      .start_pulse(rd_det)
   );

   ////////////////////////////////////////////////////////////////////////
   // Saturation flags and status word

   // A write to 1F in a channel section clears the selected channels
   assign sat_clr = (fire && r_reg.iaddr[7:0] == SAT_LOC) ?
                    r_reg.iaddr[CH_SEL_LSB +: NUM_CH] : '0;

   hira_sat_flags #(.NUM_CH(NUM_CH)) u_sat (
      .ref_clk(ref_clk),
      .reset(reset),
      .clk_en(clk_en),
      .sat_set(sat_event),
      .sat_clr(sat_clr),
      .sat_flag(sat_flag)
   );

   // Low byte: odd bits tie to zero, even bits carry the flags; high byte carries REV_CODE
   always_comb begin
      status = '0;
      status[STAT_REV_LSB +: 8] = REV_CODE;
      for (int i = 0; i < NUM_CH; i++) begin
         status[2*i] = sat_flag[i];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read source selection

   // Globals answer locally, everything else comes from the sections
   assign is_global = r_reg.iaddr <= GA_LAST;

   always_comb begin
      if (!is_global) begin
         rd_src = rd_data_in;
      end else if (r_reg.iaddr == GA_OUT_CTRL) begin
         rd_src = r_reg.g0;
      end else if (r_reg.iaddr == GA_RANGE_MAP) begin
         rd_src = r_reg.g1;
      end else if (r_reg.iaddr == GA_TEST) begin
         rd_src = r_reg.g2;
      end else begin
         rd_src = '0;
      end
   end

   // Direct read decode
   always_comb begin
      if (host.addr == DA_DATA_LO) begin
         rd_word = rd_src[15:0];
      end else if (host.addr == DA_DATA_HI) begin
         rd_word = rd_src[31:16];
      end else if (host.addr == DA_WR_ADDR) begin
         rd_word = status;
      end else if (host.addr == DA_RD_ADDR) begin
         rd_word = '0;
      end else begin
         rd_word = seq_data[host.addr[1:0]*16 +: 16];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state

   assign fire = (r_reg.st == ST_FIRE);

   always_comb begin
      r_next = r_reg;
      r_next.act = '0;
      r_next.seq_adv = '0;
      // Output word refreshed every cycle so it follows the address
      r_next.dout = rd_word;
      // Sequenced pointer steps once per read start
      if (rd_det && host.addr >= DA_SEQ_BASE) begin
         r_next.seq_adv[host.addr[1:0]] = 1'b1;
      end
      // Host writes, taken when the write strobe has settled
      if (wr_det) begin
         if (host.addr == DA_DATA_LO) begin
            r_next.hold[15:0] = host.data;
         end else if (host.addr == DA_DATA_HI) begin
            r_next.hold[31:16] = host.data;
         end else if (host.addr == DA_WR_ADDR) begin
            r_next.iaddr = host.data;
         end else if (host.addr == DA_RD_ADDR) begin
            r_next.iaddr = host.data;
         end
         // Direct 4 to 7 fall through untouched
      end
      case (r_reg.st)
         ST_IDLE: begin
            if (wr_det && host.addr == DA_WR_ADDR) begin
               // Snapshot so a fast host cannot corrupt the transfer
               r_next.wdata = r_reg.hold;
               r_next.st = ST_FIRE;
            end
         end
         ST_FIRE: begin
            r_next.st = ST_IDLE;
            if (r_reg.iaddr == GA_OUT_CTRL) begin
               r_next.g0 = r_reg.wdata;
            end else if (r_reg.iaddr == GA_RANGE_MAP) begin
               r_next.g1 = r_reg.wdata;
            end else if (r_reg.iaddr == GA_TEST) begin
               r_next.g2 = r_reg.wdata;
            end else if (r_reg.iaddr == GA_TEST_STB) begin
               r_next.act.test_data = 1'b1;
            end else if (r_reg.iaddr == GA_SYNC_STB) begin
               r_next.act.sync_out = 1'b1;
            end else if (r_reg.iaddr == GA_SYNC_FB) begin
               r_next.act.sync_out_fb = 1'b1;
            end else if (r_reg.iaddr == GA_SOFT_RST) begin
               r_next.act.soft_reset = 1'b1;
            end
            // Reserved globals 7 to FF leave everything alone
         end
         default: begin
            r_next.st = ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         r_reg.st <= ST_IDLE;
         r_reg.hold <= HOLD_RESET;
         r_reg.iaddr <= IADDR_RESET;
         r_reg.wdata <= HOLD_RESET;
         r_reg.g0 <= GLB_RESET;
         r_reg.g1 <= GLB_RESET;
         r_reg.g2 <= GLB_RESET;
         r_reg.dout <= '0;
         r_reg.seq_adv <= '0;
         r_reg.act <= '0;
      end else if (clk_en) begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   // The write bus strobes sections only; globals never leave the port
   assign wr_bus.strobe = fire & ~is_global;
   assign wr_bus.addr = r_reg.iaddr;
   assign wr_bus.data = r_reg.wdata;
   assign rd_addr = r_reg.iaddr;
   assign data_out = r_reg.dout;
   assign data_oe = rd_level;
   assign seq_advance = r_reg.seq_adv;
   assign actions = r_reg.act;
   assign glb_out_ctrl = r_reg.g0;
   assign glb_range_map = r_reg.g1;
   assign glb_test = r_reg.g2;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset || !clk_en);

   sequence s_wr_at(logic [2:0] a);
      wr_det && host.addr == a;
   endsequence

   sequence s_rd_at(logic [2:0] a);
      rd_level && host.addr == a;
   endsequence

   // A strobe that stays up a second cycle would write twice
   sequence s_pulse(sig);
      sig ##1 !sig;
   endsequence

   a_hold_low_load: assert property (s_wr_at(DA_DATA_LO) |=>
      r_reg.hold[15:0] == $past(host.data))
      else $error("low holding half not loaded");

   a_hold_high_load: assert property (s_wr_at(DA_DATA_HI) |=>
      r_reg.hold[31:16] == $past(host.data))
      else $error("high holding half not loaded");

   a_strobe_once: assert property (s_wr_at(DA_WR_ADDR) ##0 !fire
      |=> s_pulse(fire))
      else $error("internal write not exactly one pulse");

   a_read_addr_quiet: assert property (s_wr_at(DA_RD_ADDR) ##0 !fire
      |=> !fire && r_reg.iaddr == $past(host.data))
      else $error("read address write fired a strobe");

   a_read_low_word: assert property (s_rd_at(DA_DATA_LO) ##0 !fire
      && !wr_det |=> data_out == $past(rd_src[15:0]))
      else $error("indirect low read wrong");

   a_read_high_word: assert property (s_rd_at(DA_DATA_HI) |=>
      data_out == $past(rd_src[31:16]))
      else $error("indirect high read wrong");

   a_status_odd_zero: assert property (s_rd_at(DA_WR_ADDR) |=>
      (data_out & 16'h00aa) == 16'h0000 &&
      data_out[15:8] == REV_CODE)
      else $error("status word malformed");

   a_seq_step: assert property (rd_det && host.addr == 3'h5 |=>
      seq_advance == 4'h2)
      else $error("sequenced read stepped wrong channel");

   a_glb_store: assert property (fire && r_reg.iaddr == GA_TEST |=>
      glb_test == $past(r_reg.wdata) && !wr_bus.strobe)
      else $error("global test location not stored");

   a_soft_reset: assert property (fire && r_reg.iaddr == GA_SOFT_RST
      |=> s_pulse(actions.soft_reset))
      else $error("soft reset strobe wrong");

   a_reserved_write: assert property (wr_det && host.addr >= 3'h4
      |=> r_reg.hold == $past(r_reg.hold) &&
      r_reg.iaddr == $past(r_reg.iaddr))
      else $error("reserved direct write changed state");

   a_ctrl_store: assert property (fire && r_reg.iaddr == GA_OUT_CTRL
      |=> glb_out_ctrl == $past(r_reg.wdata))
      else $error("global output control not stored");

   a_range_store: assert property (fire && r_reg.iaddr == GA_RANGE_MAP
      |=> glb_range_map == $past(r_reg.wdata))
      else $error("global range mapping not stored");

   a_wr_scope: assert property (fire |->
      wr_bus.strobe == (r_reg.iaddr[15:8] != 8'h00))
      else $error("internal write strobe on wrong address range");

   a_sat_clear: assert property (fire && r_reg.iaddr[7:0] == SAT_LOC
      && r_reg.iaddr[CH_SEL_LSB] && !sat_event[0] |=> !sat_flag[0])
      else $error("saturation flag not cleared by host write");

endmodule : hira_host_port

// ==== hira_host_model.sv ====
// Purpose: Behavioural host processor on the parallel register port
// Assumes: Pins change 1 ns after a rising edge of ref_clk
// Notes: Released data lines show the inverse of the last value
`timescale 1ns/100ps
module hira_host_model (
   input wire logic ref_clk, // System clock
   output hira_pkg::hira_pins_t pins, // Host bus pins
   input wire logic [15:0] data_out, // Port read data
   input wire logic data_oe // Port data enable
);
   import hira_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Idle bus at time zero, strobes inactive
   initial begin
      pins = {1'b1, 1'b1, 1'b1, 3'h0, 16'h0000};
   end

   // Strobe held over four edges since the port needs three stable ones
   task automatic bus_write(input logic [2:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      #1;
      pins = {1'b0, 1'b0, 1'b1, a, d};
      repeat (4) @(posedge ref_clk);
      #1;
      pins = {1'b1, 1'b1, 1'b1, a, ~d}; // Undriven lines not left at d
      repeat ((a == 3'h2) ? 5 : 3) @(posedge ref_clk);
   endtask : bus_write

   // Result carries the enable on top so a dead bus is seen too
   task automatic bus_read(input logic [2:0] a, output logic [16:0] got);
      @(posedge ref_clk);
      #1;
      pins = {1'b0, 1'b1, 1'b0, a, pins.data};
      repeat (4) @(posedge ref_clk);
      #1;
      got = {data_oe, data_out};
      pins = {1'b1, 1'b1, 1'b1, a, ~pins.data};
      repeat (3) @(posedge ref_clk);
   endtask : bus_read

endmodule : hira_host_model

// ==== test_hira_host_port.sv ====
// Purpose: Self-checking bench of the host indirect register port
// Assumes: Host processor model drives all pin traffic
// Notes: Rows are op nibble (0-7 write, 8-f read at nibble-8) and data
`timescale 1ns/100ps
module test_hira_host_port;
   import hira_pkg::*;

   localparam logic [7:0] REV = 8'h3c; // Arbitrary revision value
   localparam logic [19:0] ROWS [30] = '{
      20'h01234, 20'h1abcd, 20'h20000, 20'h30000, 20'h81234, 20'h9abcd,
      20'h05678, 20'h19abc, 20'h20001, 20'h85678, 20'h99abc,
      20'h00f0f, 20'h1f0f0, 20'h20002, 20'h80f0f, 20'h9f0f0,
      20'h30000, 20'h81234, 20'h31105, 20'h8eefa, 20'h91105,
      20'hb0000, 20'hc1111, 20'hd2222, 20'he3333, 20'hf4444,
      20'h7ffff, 20'h4ffff, 20'h8eefa, 20'ha3c00};
   logic ref_clk;
   logic reset;
   logic clk_en;
   hira_pins_t host_pins;
   logic [15:0] data_out;
   logic data_oe;
   hira_wr_t wr_bus;
   hira_wr_t last_wr;
   logic [15:0] rd_addr;
   logic [31:0] rd_data_in;
   logic [63:0] seq_data;
   logic [3:0] seq_advance;
   logic [3:0] sat_event;
   hira_act_t actions;
   logic [31:0] glb_out_ctrl;
   logic [31:0] glb_range_map;
   logic [31:0] glb_test;
   logic [16:0] got;
   int failures;
   int total_checks;
   int strobe_cnt;
   int act_cnt [4];
   int seq_cnt [4];

   ////////////////////////////////////////////////////////////////////////
   // Sections answer with a pattern tied to the address they are given
   assign rd_data_in = {rd_addr, ~rd_addr};
   assign seq_data = 64'h4444_3333_2222_1111;

   hira_host_port #(.NUM_CH(4), .REV_CODE(REV)) u_hira_host_port (
      .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
      .host(host_pins), .data_out(data_out), .data_oe(data_oe),
      .wr_bus(wr_bus), .rd_addr(rd_addr), .rd_data_in(rd_data_in),
      .seq_data(seq_data), .seq_advance(seq_advance),
      .sat_event(sat_event), .actions(actions),
      .glb_out_ctrl(glb_out_ctrl), .glb_range_map(glb_range_map),
      .glb_test(glb_test));

   hira_host_model u_hira_host_model (
      .ref_clk(ref_clk), .pins(host_pins), .data_out(data_out),
      .data_oe(data_oe));

   // Clock of 10 ns
   always #5 ref_clk = ~ref_clk;

   // Pulse counters, since strobes stand for one cycle only
   always @(posedge ref_clk) begin
      if (!reset) begin
         if (wr_bus.strobe === 1'b1) begin
            strobe_cnt++;
            last_wr = wr_bus;
         end
         for (int i = 0; i < 4; i++) begin
            act_cnt[i] += (actions[i] === 1'b1);
            seq_cnt[i] += (seq_advance[i] === 1'b1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [31:0] exp,
         input logic [31:0] seen);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic rd_chk(input logic [2:0] a, input logic [15:0] exp);
      u_hira_host_model.bus_read(a, got);
      check($sformatf("read at %0d", a), {1'b1, exp}, got);
   endtask : rd_chk

   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      u_hira_host_model.bus_write(a, d);
   endtask : wr

   task automatic test_done;
      if (failures == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : test_done

   // Watchdog far beyond the few hundred cycles the run needs
   initial begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      test_done;
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      ref_clk = 1'b0;
      reset = 1'b1;
      clk_en = 1'b1;
      sat_event = 4'h0;
      repeat (5) @(posedge ref_clk);
      #1;
      reset = 1'b0;
      for (int i = 0; i < 30; i++) begin
         if (ROWS[i][19]) begin
            u_hira_host_model.bus_read(ROWS[i][18:16], got);
            check($sformatf("row %0d", i), {1'b1, ROWS[i][15:0]}, got);
         end else begin
            wr(ROWS[i][18:16], ROWS[i][15:0]);
         end
      end
      check("out ctrl", 32'habcd_1234, glb_out_ctrl);
      check("range map", 32'h9abc_5678, glb_range_map);
      check("test reg", 32'hf0f0_0f0f, glb_test);
      for (int i = 0; i < 4; i++) begin
         check("seq step", 32'h1, seq_cnt[i]);
      end
      // Every action location fires its own strobe, once
      for (int i = 3; i < 7; i++) begin
         wr(3'h2, 16'(i));
      end
      for (int i = 0; i < 4; i++) begin
         check("action", 32'h1, act_cnt[i]);
      end
      wr(3'h3, 16'h0004);
      rd_chk(3'h0, 16'h0000);
      // Reserved globals leave everything as it was
      wr(3'h0, 16'hffff);
      wr(3'h1, 16'hffff);
      wr(3'h2, 16'h0007);
      wr(3'h2, 16'h00ff);
      rd_chk(3'h0, 16'h0000);
      check("out ctrl kept", 32'habcd_1234, glb_out_ctrl);
      check("test kept", 32'hf0f0_0f0f, glb_test);
      check("no internal", 32'h0, strobe_cnt);
      for (int i = 0; i < 4; i++) begin
         check("act kept", 32'h1, act_cnt[i]);
      end
      // Broadcast write to two channels passes as one internal write
      wr(3'h0, 16'haaaa);
      wr(3'h1, 16'h5555);
      wr(3'h2, 16'h3105);
      check("one strobe", 32'h1, strobe_cnt);
      check("wr addr", 32'h3105, last_wr.addr);
      check("wr data", 32'h5555_aaaa, last_wr.data);
      // Saturation flags stick and clear per channel
      @(posedge ref_clk);
      #1;
      sat_event = 4'hf;
      @(posedge ref_clk);
      #1;
      sat_event = 4'h0;
      rd_chk(3'h2, {REV, 8'h55});
      wr(3'h2, 16'h101f);
      rd_chk(3'h2, {REV, 8'h54});
      wr(3'h2, 16'he01f);
      rd_chk(3'h2, {REV, 8'h00});
      // A write made entirely while frozen must leave no trace
      #1;
      clk_en = 1'b0;
      wr(3'h3, 16'h0001);
      #1;
      clk_en = 1'b1;
      rd_chk(3'h0, 16'h1fe0);
      // Second reset clears the stored globals and the address
      #1;
      reset = 1'b1;
      repeat (5) @(posedge ref_clk);
      #1;
      reset = 1'b0;
      check("reset ctrl", 32'h0, glb_out_ctrl);
      check("reset map", 32'h0, glb_range_map);
      check("reset test", 32'h0, glb_test);
      check("reset addr", 32'h0, rd_addr);
      test_done;
   end

endmodule : test_hira_host_port
